// ===== dxe_consts.vh
// Contract
// - a divide step subtracts the second operand from the first when the divide flag is 1, adds them when it is 0, and writes the result to the destination.
// - after that add or subtract the new divide flag is the inverse of carry-out xor old divide flag xor negative flag.
// - the divide step loads the negative flag with the sign bit of the add or subtract result.
// - the divide step shifts Q left by one, fills the low bit with the new divide flag and writes it back to Q.
// - with the immediate-select bit 0 the second operand is a register, with it 1 it is the 8-bit constant zero-extended to 32 bits.
// - the unimplemented floating-point multiply, add, subtract, single-to-double multiply and compare instructions each take their own trap with the indirect pointers naming both sources and the destination.
// - emulate loads the first indirect pointer with its first operand register number, the second with its second, then traps at the encoded vector.
// - emulate also changes the third indirect pointer, whose value has no meaning.
// - emulate from user mode with a vector of 0 to 63 takes a protection violation trap instead.
// - emulate takes a protection violation trap when either operand register is protected in the bank protection register.
// - byte extract puts the first-operand byte chosen by the byte pointer into the low byte of the second operand and writes that word.
// - signed half-word extract takes the first-operand half-word chosen by the byte pointer, sign-extends it to 32 bits and writes it.
// - funnel extract shifts first operand over second operand left by the funnel shift count and writes the upper 32 bits.
`ifndef DXE_CONSTS_VH
`define DXE_CONSTS_VH
// ==============================
// register byte addresses
`define DXE_A_INSN 8'h00
`define DXE_A_OPA 8'h04
`define DXE_A_OPB 8'h08
`define DXE_A_ALU 8'h0c
`define DXE_A_Q 8'h10
`define DXE_A_MODE 8'h14
`define DXE_A_PROT 8'h18
`define DXE_A_RES 8'h1c
`define DXE_A_TRAP 8'h20
`define DXE_A_IPA 8'h24
`define DXE_A_IPB 8'h28
`define DXE_A_IPC 8'h2c
`define DXE_A_IST 8'h30
`define DXE_A_IMSK 8'h34
// ==============================
// alu status fields
`define DXE_FC_LSB 0
`define DXE_FC_MSB 4
`define DXE_BP_LSB 5
`define DXE_BP_MSB 6
`define DXE_N_BIT 8
`define DXE_DF_BIT 9
`define DXE_TRAP_BIT 8
`define DXE_IST_DONE 0
`define DXE_IST_TRAP 1
// ==============================
// instruction fields
`define DXE_OP_MSB 31
`define DXE_OP_LSB 24
`define DXE_RC_MSB 23
`define DXE_RC_LSB 16
`define DXE_RA_MSB 15
`define DXE_RA_LSB 8
`define DXE_RB_MSB 7
`define DXE_RB_LSB 0
// ==============================
// opcodes; paired ones named by their even code
`define DXE_OP_DIVSTEP 8'h6a
`define DXE_OP_BYTE_EXTRACT_OP 8'h0a
`define DXE_OP_SIGNED_HALFWORD_EXTRACT_OP 8'h7e
`define DXE_OP_EXTRACT 8'h7a
`define DXE_OP_EMULATE 8'hd7
`define DXE_OP_SINGLE_ADD_OP 8'hf0
`define DXE_OP_FMUL 8'hf4
`define DXE_OP_DOUBLE_MULTIPLY_OP 8'hf5
`define DXE_OP_DOUBLE_SUBTRACT_OP 8'hf3
`define DXE_OP_SINGLE_TO_DOUBLE_MULTIPLY_OP 8'hf9
`define DXE_OP_FGE 8'hef
`define DXE_OP_FGT 8'hed
// ==============================
// trap vectors
`define DXE_V_PROT 8'h05
`define DXE_V_USER_MAX 8'h3f
`define DXE_V_SINGLE_ADD_OP 8'hf0
`define DXE_V_FMUL 8'hf4
`define DXE_V_DOUBLE_MULTIPLY_OP 8'hf5
`define DXE_V_DOUBLE_SUBTRACT_OP 8'hf3
`define DXE_V_SINGLE_TO_DOUBLE_MULTIPLY_OP 8'hf9
`define DXE_V_FGE 8'hef
`define DXE_V_FGT 8'hed
`define DXE_RESP_OK 2'b00
`define DXE_RESP_DEC 2'b11
`endif

// ===== dxe_alu.v
`timescale 1ns/100ps
`include "dxe_consts.vh"
module dxe_alu (
   input wire [31:0] insn,
   input wire [31:0] opa,
   input wire [31:0] opb_reg,
   input wire df,
   input wire neg,
   input wire [1:0] bp,
   input wire [4:0] fc,
   input wire [31:0] q,
   input wire user_mode,
   input wire [15:0] prot,
   output reg wr_dest,
   output reg [31:0] dest,
   output reg wr_div,
   output wire df_nxt,
   output wire n_nxt,
   output wire [31:0] q_nxt,
   output reg trap,
   output reg [7:0] vec,
   output reg [7:0] indirect_pointer_a,
   output reg [7:0] indirect_pointer_b,
   output reg [7:0] indirect_pointer_c
);
   wire [7:0] op = insn[`DXE_OP_MSB:`DXE_OP_LSB];
   wire [7:0] op_pair = {op[7:1], 1'b0};
   wire [7:0] rc = insn[`DXE_RC_MSB:`DXE_RC_LSB];
   wire [7:0] ra = insn[`DXE_RA_MSB:`DXE_RA_LSB];
   wire [7:0] rb = insn[`DXE_RB_MSB:`DXE_RB_LSB];
   wire [31:0] opb = op[0] ? {24'h0, rb} : opb_reg;
   wire [32:0] sum = {1'b0, opa} + {1'b0, df ? ~opb : opb} +
                     {32'h0, df};
   assign df_nxt = ~(sum[32] ^ df ^ neg);
   assign n_nxt = sum[31];
   assign q_nxt = {q[30:0], df_nxt};
   // byte pointer 0 names the most significant byte
   wire [4:0] bsh = {~bp, 3'b000};
   wire [31:0] bsel = opa >> bsh;
   wire [15:0] hsel = bp[1] ? opa[15:0] : opa[31:16];
   wire [63:0] fun = {opa, opb} << fc;
   wire prot_hit = prot[ra[7:4]] | prot[rb[7:4]];
   always @* begin
      wr_dest = 1'b0;
      dest = 32'h0;
      wr_div = 1'b0;
      trap = 1'b0;
      vec = 8'h0;
      indirect_pointer_a = ra;
      indirect_pointer_b = rb;
      indirect_pointer_c = rc;
      if (op_pair == `DXE_OP_DIVSTEP) begin
         wr_dest = 1'b1;
         wr_div = 1'b1;
         dest = sum[31:0];
      end else if (op_pair == `DXE_OP_BYTE_EXTRACT_OP) begin
         wr_dest = 1'b1;
         dest = {opb[31:8], bsel[7:0]};
      end else if (op == `DXE_OP_SIGNED_HALFWORD_EXTRACT_OP) begin
         wr_dest = 1'b1;
         dest = {{16{hsel[15]}}, hsel};
      end else if (op_pair == `DXE_OP_EXTRACT) begin
         wr_dest = 1'b1;
         dest = fun[63:32];
      end else if (op == `DXE_OP_EMULATE) begin
         trap = 1'b1;
         indirect_pointer_a = ra;
         indirect_pointer_b = rb;
         indirect_pointer_c = rc;
         if ((user_mode && rc <= `DXE_V_USER_MAX) || prot_hit)
            vec = `DXE_V_PROT;
         else
            vec = rc;
      end else if (op == `DXE_OP_SINGLE_ADD_OP || op == `DXE_OP_FMUL ||
                   op == `DXE_OP_DOUBLE_MULTIPLY_OP || op == `DXE_OP_DOUBLE_SUBTRACT_OP ||
                   op == `DXE_OP_SINGLE_TO_DOUBLE_MULTIPLY_OP || op == `DXE_OP_FGE ||
                   op == `DXE_OP_FGT) begin
         trap = 1'b1;
         vec = op;
      end
   end
endmodule

// ===== dxe_exec_top.v
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "dxe_consts.vh"
module dxe_exec_top #(
   parameter AW = 8
) (
   input wire clk,
   input wire rstn,
   input wire [AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg irq
);
   // ==============================
   // architectural state
   reg [31:0] insn_r;
   reg exec_r;
   reg [31:0] opa_r;
   reg [31:0] opb_r;
   reg [4:0] fc_r;
   reg [1:0] bp_r;
   reg n_r;
   reg df_r;
   reg [31:0] q_r;
   reg user_r;
   reg [15:0] prot_r;
   reg [31:0] res_r;
   reg trap_r;
   reg [7:0] vec_r;
   reg [7:0] ipa_r;
   reg [7:0] ipb_r;
   reg [7:0] ipc_r;
   reg [1:0] ist_r;
   reg [1:0] imsk_r;
   reg [1:0] ist_nxt;
   wire wr_dest;
   wire [31:0] dest;
   wire wr_div;
   wire df_nxt;
   wire n_nxt;
   wire [31:0] q_nxt;
   wire a_trap;
   wire [7:0] a_vec;
   wire [7:0] a_ipa;
   wire [7:0] a_ipb;
   wire [7:0] a_ipc;

   dxe_alu dxe_alu_inst (
      .insn(insn_r),
      .opa(opa_r),
      .opb_reg(opb_r),
      .df(df_r),
      .neg(n_r),
      .bp(bp_r),
      .fc(fc_r),
      .q(q_r),
      .user_mode(user_r),
      .prot(prot_r),
      .wr_dest(wr_dest),
      .dest(dest),
      .wr_div(wr_div),
      .df_nxt(df_nxt),
      .n_nxt(n_nxt),
      .q_nxt(q_nxt),
      .trap(a_trap),
      .vec(a_vec),
      .indirect_pointer_a(a_ipa),
      .indirect_pointer_b(a_ipb),
      .indirect_pointer_c(a_ipc)
   );

   // ==============================
   // axi4-lite write path
   reg [AW-1:0] aw_addr_r;
   reg aw_have_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg w_have_r;
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire [AW-1:0] wa = aw_hs ? s_axi_awaddr : aw_addr_r;
   wire [31:0] wd = w_hs ? s_axi_wdata : w_data_r;
   wire [3:0] ws = w_hs ? s_axi_wstrb : w_strb_r;
   wire aw_ok = aw_hs | aw_have_r;
   wire w_ok = w_hs | w_have_r;
   wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;
   wire [31:0] wm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   reg wr_hit;

   always @* begin
      if (wa == `DXE_A_INSN || wa == `DXE_A_OPA || wa == `DXE_A_OPB ||
          wa == `DXE_A_ALU || wa == `DXE_A_Q || wa == `DXE_A_MODE ||
          wa == `DXE_A_PROT || wa == `DXE_A_IMSK)
         wr_hit = 1'b1;
      else if (wa == `DXE_A_RES || wa == `DXE_A_TRAP ||
               wa == `DXE_A_IPA || wa == `DXE_A_IPB ||
               wa == `DXE_A_IPC || wa == `DXE_A_IST)
         wr_hit = 1'b1;
      else
         wr_hit = 1'b0;
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DXE_RESP_OK;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= {AW{1'b0}};
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `DXE_RESP_OK : `DXE_RESP_DEC;
         end else begin
            aw_have_r <= aw_ok;
            w_have_r <= w_ok;
            if (s_axi_bvalid && s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
         // accept each channel once per write, none while answering
         s_axi_awready <= ~aw_ok & ~do_wr & ~s_axi_bvalid & ~s_axi_awready;
         s_axi_wready <= ~w_ok & ~do_wr & ~s_axi_bvalid & ~s_axi_wready;
      end
   end

   // ==============================
   // axi4-lite read path
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   reg [31:0] rd_val;
   reg rd_hit;

   always @* begin
      rd_hit = 1'b1;
      if (s_axi_araddr == `DXE_A_INSN)
         rd_val = insn_r;
      else if (s_axi_araddr == `DXE_A_OPA)
         rd_val = opa_r;
      else if (s_axi_araddr == `DXE_A_OPB)
         rd_val = opb_r;
      else if (s_axi_araddr == `DXE_A_ALU)
         rd_val = {22'h0, df_r, n_r, 1'b0, bp_r, fc_r};
      else if (s_axi_araddr == `DXE_A_Q)
         rd_val = q_r;
      else if (s_axi_araddr == `DXE_A_MODE)
         rd_val = {31'h0, user_r};
      else if (s_axi_araddr == `DXE_A_PROT)
         rd_val = {16'h0, prot_r};
      else if (s_axi_araddr == `DXE_A_RES)
         rd_val = res_r;
      else if (s_axi_araddr == `DXE_A_TRAP)
         rd_val = {23'h0, trap_r, vec_r};
      else if (s_axi_araddr == `DXE_A_IPA)
         rd_val = {24'h0, ipa_r};
      else if (s_axi_araddr == `DXE_A_IPB)
         rd_val = {24'h0, ipb_r};
      else if (s_axi_araddr == `DXE_A_IPC)
         rd_val = {24'h0, ipc_r};
      else if (s_axi_araddr == `DXE_A_IST)
         rd_val = {30'h0, ist_r};
      else if (s_axi_araddr == `DXE_A_IMSK)
         rd_val = {30'h0, imsk_r};
      else begin
         rd_val = 32'h0;
         rd_hit = 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `DXE_RESP_OK;
      end else begin
         if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `DXE_RESP_OK : `DXE_RESP_DEC;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         s_axi_arready <= ~ar_hs & ~s_axi_rvalid & ~s_axi_arready;
      end
   end

   // ==============================
   // interrupt status: read clears, a new event wins
   wire ist_rd = ar_hs && s_axi_araddr == `DXE_A_IST;

   always @* begin
      ist_nxt = ist_rd ? 2'b00 : ist_r;
      if (exec_r) begin
         ist_nxt[`DXE_IST_DONE] = 1'b1;
         if (a_trap)
            ist_nxt[`DXE_IST_TRAP] = 1'b1;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ist_r <= 2'b00;
         irq <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         irq <= |(ist_nxt & imsk_r);
      end
   end

   // ==============================
   // software registers and instruction execution
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         insn_r <= 32'h0;
         exec_r <= 1'b0;
         opa_r <= 32'h0;
         opb_r <= 32'h0;
         fc_r <= 5'h00;
         bp_r <= 2'h0;
         n_r <= 1'b0;
         df_r <= 1'b0;
         q_r <= 32'h0;
         user_r <= 1'b0;
         prot_r <= 16'h0;
         imsk_r <= 2'b00;
         res_r <= 32'h0;
         trap_r <= 1'b0;
         vec_r <= 8'h00;
         ipa_r <= 8'h00;
         ipb_r <= 8'h00;
         ipc_r <= 8'h00;
      end else begin
         exec_r <= do_wr && wa == `DXE_A_INSN;
         if (exec_r) begin
            // operands are the staged register contents
            trap_r <= a_trap;
            if (a_trap) begin
               vec_r <= a_vec;
               ipa_r <= a_ipa;
               ipb_r <= a_ipb;
               ipc_r <= a_ipc;
            end
            if (wr_dest)
               res_r <= dest;
            if (wr_div) begin
               df_r <= df_nxt;
               n_r <= n_nxt;
               q_r <= q_nxt;
            end
         end else if (do_wr) begin
            if (wa == `DXE_A_INSN)
               insn_r <= (insn_r & ~wm) | (wd & wm);
            else if (wa == `DXE_A_OPA)
               opa_r <= (opa_r & ~wm) | (wd & wm);
            else if (wa == `DXE_A_OPB)
               opb_r <= (opb_r & ~wm) | (wd & wm);
            else if (wa == `DXE_A_Q)
               q_r <= (q_r & ~wm) | (wd & wm);
            else if (wa == `DXE_A_ALU) begin
               if (ws[0]) begin
                  fc_r <= wd[`DXE_FC_MSB:`DXE_FC_LSB];
                  bp_r <= wd[`DXE_BP_MSB:`DXE_BP_LSB];
               end
               if (ws[1]) begin
                  n_r <= wd[`DXE_N_BIT];
                  df_r <= wd[`DXE_DF_BIT];
               end
            end else if (wa == `DXE_A_MODE) begin
               if (ws[0])
                  user_r <= wd[0];
            end else if (wa == `DXE_A_PROT) begin
               if (ws[0])
                  prot_r[7:0] <= wd[7:0];
               if (ws[1])
                  prot_r[15:8] <= wd[15:8];
            end else if (wa == `DXE_A_IMSK) begin
               if (ws[0])
                  imsk_r <= wd[1:0];
            end
         end
      end
   end
endmodule

// ===== dxe_exec_sva.sv
`timescale 1ns/100ps
module dxe_exec_sva (
   input wire clk,
   input wire rstn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // ==============================
   // handshakes
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_ar;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_aw_pulse;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   property p_wr_answer;
      s_wr |=> s_axi_bvalid;
   endproperty
   property p_rd_answer;
      s_ar |=> s_axi_rvalid;
   endproperty
   property p_no_take_in_b;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_no_take_in_r;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_rresp_code;
      s_axi_rvalid |-> s_axi_rresp == 2'b00 || s_axi_rresp == 2'b11;
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped or changed");
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped or changed");
   a_aw_pulse: assert property (p_aw_pulse)
      else $error("awready not a pulse");
   a_wr_answer: assert property (p_wr_answer)
      else $error("no write response");
   a_rd_answer: assert property (p_rd_answer)
      else $error("no read response");
   a_no_take_in_b: assert property (p_no_take_in_b)
      else $error("write taken while response pending");
   a_no_take_in_r: assert property (p_no_take_in_r)
      else $error("read taken while data pending");
   a_rresp_code: assert property (p_rresp_code)
      else $error("bad read response code");
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
`include "dxe_consts.vh"
module tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
   int fails = 0, cmp_count = 0;
   always #50 clk = ~clk;
   dxe_exec_top dxe_exec_top_inst (.clk, .rstn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   // ==============================
   // bus master and checks
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input [31:0] e, input [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input [7:0] a, input [31:0] d);
      int i;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50 && !s_axi_bvalid; i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      last_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      chk("write wait", 1, i < 50);
      if (i == 50) report_and_stop();
   endtask
   task automatic rd(input [7:0] a, input [31:0] e, input string nm);
      int i;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50 && !s_axi_rvalid; i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      last_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk("read wait", 1, i < 50);
      if (i == 50) report_and_stop();
      chk(nm, e, s_axi_rdata);
   endtask
   task automatic ex(input [7:0] op, dst, ra, rb);
      wr(`DXE_A_INSN, {op, dst, ra, rb});
   endtask
   // ==============================
   // scenarios
   task automatic t_div;
      // flag update uses the n flag from before the step
      wr(`DXE_A_ALU, 32'h265);
      wr(`DXE_A_OPA, 32'h10);
      wr(`DXE_A_OPB, 32'h3);
      wr(`DXE_A_Q, 32'h80000001);
      ex(`DXE_OP_DIVSTEP, 8'h01, 8'h02, 8'h03);
      rd(`DXE_A_RES, 32'hd, "sub result");
      rd(`DXE_A_ALU, 32'h265, "sub flags");
      rd(`DXE_A_Q, 32'h3, "sub q");
      wr(`DXE_A_ALU, 32'h065);
      wr(`DXE_A_OPA, 32'hfffffffe);
      wr(`DXE_A_OPB, 32'h100);
      ex(`DXE_OP_DIVSTEP | 8'h01, 8'h01, 8'h02, 8'h05);
      rd(`DXE_A_RES, 32'h3, "add const");
      rd(`DXE_A_ALU, 32'h065, "add flags");
      rd(`DXE_A_Q, 32'h6, "add q");
      wr(`DXE_A_ALU, 32'h265);
      wr(`DXE_A_OPA, 32'h1);
      wr(`DXE_A_OPB, 32'h2);
      ex(`DXE_OP_DIVSTEP, 8'h01, 8'h02, 8'h03);
      rd(`DXE_A_RES, 32'hffffffff, "neg result");
      rd(`DXE_A_ALU, 32'h165, "neg flags");
      rd(`DXE_A_Q, 32'hc, "neg q");
      $display("test divide step done");
   endtask
   task automatic t_ext;
      logic [63:0] w;
      wr(`DXE_A_OPA, 32'h11223344);
      wr(`DXE_A_OPB, 32'haabbccdd);
      for (int k = 0; k < 4; k++) begin
         wr(`DXE_A_ALU, k << 5);
         ex(`DXE_OP_BYTE_EXTRACT_OP, 8'h01, 8'h02, 8'h03);
         w = 64'h11223344 >> (8 * (3 - k));
         rd(`DXE_A_RES, {24'haabbcc, w[7:0]}, "byte");
      end
      ex(`DXE_OP_BYTE_EXTRACT_OP | 8'h01, 8'h01, 8'h02, 8'h77);
      rd(`DXE_A_RES, 32'h44, "byte const");
      for (int k = 0; k < 3; k++) begin
         wr(`DXE_A_ALU, k == 2 ? 8 : k == 1 ? 4 : 31);
         ex(`DXE_OP_EXTRACT, 8'h01, 8'h02, 8'h03);
         w = 64'h11223344aabbccdd << (k == 2 ? 8 : k == 1 ? 4 : 31);
         rd(`DXE_A_RES, w[63:32], "funnel");
      end
      ex(`DXE_OP_EXTRACT | 8'h01, 8'h01, 8'h02, 8'h5a);
      rd(`DXE_A_RES, 32'h22334400, "funnel const");
      wr(`DXE_A_OPA, 32'h80017ffe);
      wr(`DXE_A_ALU, 32'h00);
      ex(`DXE_OP_SIGNED_HALFWORD_EXTRACT_OP, 8'h01, 8'h02, 8'h00);
      rd(`DXE_A_RES, 32'hffff8001, "half upper");
      wr(`DXE_A_ALU, 32'h40);
      ex(`DXE_OP_SIGNED_HALFWORD_EXTRACT_OP, 8'h01, 8'h02, 8'h00);
      rd(`DXE_A_RES, 32'h00007ffe, "half lower");
      $display("test extract done");
   endtask
   task automatic t_fp;
      logic [7:0] ops[7] = '{8'hf0, 8'hf4, 8'hf5, 8'hf3, 8'hf9, 8'hef, 8'hed};
      foreach (ops[i]) begin
         ex(ops[i], 8'(8'h40 + i), 8'(8'h50 + i), 8'(8'h60 + i));
         rd(`DXE_A_TRAP, {23'h0, 1'b1, ops[i]}, "fp trap");
         rd(`DXE_A_IPA, 8'h50 + i, "fp ipa");
         rd(`DXE_A_IPB, 8'h60 + i, "fp ipb");
         rd(`DXE_A_IPC, 8'h40 + i, "fp ipc");
         rd(`DXE_A_RES, 32'h00007ffe, "fp dest kept");
         rd(`DXE_A_ALU, 32'h40, "fp flags kept");
      end
      $display("test float traps done");
   endtask
   task automatic t_emu;
      // mode, protect, vector, ra, rb, expected vector
      logic [47:0] tb[6] = '{48'h00_00_10_31_42_10, 48'h00_00_03_31_42_03,
         48'h01_00_3f_31_42_05, 48'h01_00_40_31_42_40,
         48'h00_04_50_25_10_05, 48'h00_04_50_30_2f_05};
      foreach (tb[i]) begin
         wr(`DXE_A_MODE, tb[i][47:40]);
         wr(`DXE_A_PROT, tb[i][39:32]);
         ex(`DXE_OP_EMULATE, tb[i][31:24], tb[i][23:16], tb[i][15:8]);
         rd(`DXE_A_TRAP, {24'h1, tb[i][7:0]}, "vec");
         if (tb[i][7:0] != 8'h05) begin
            rd(`DXE_A_IPA, tb[i][23:16], "emu ipa");
            rd(`DXE_A_IPB, tb[i][15:8], "emu ipb");
         end
      end
      $display("test emulate done");
   endtask
   task automatic t_irq;
      wr(`DXE_A_IMSK, 32'h0);
      rd(`DXE_A_IST, 32'h3, "status sticky");
      ex(`DXE_OP_SINGLE_ADD_OP, 8'h01, 8'h02, 8'h03);
      repeat (2) @(posedge clk);
      chk("irq masked", 0, irq);
      wr(`DXE_A_IMSK, 32'h2);
      repeat (2) @(posedge clk);
      chk("irq raised", 1, irq);
      rd(`DXE_A_IST, 32'h3, "status trap");
      repeat (2) @(posedge clk);
      chk("irq cleared", 0, irq);
      wr(8'h40, 32'h1);
      chk("unmapped write", 2'b11, last_resp);
      rd(8'h40, 32'h0, "unmapped read");
      chk("unmapped resp", 2'b11, last_resp);
      wr(`DXE_A_RES, 32'h1234);
      chk("ro write resp", 2'b00, last_resp);
      rd(`DXE_A_RES, 32'h00007ffe, "ro kept");
      // only the middle two byte lanes may change
      s_axi_wstrb <= 4'h6;
      wr(`DXE_A_OPA, 32'h0);
      s_axi_wstrb <= 4'hf;
      rd(`DXE_A_OPA, 32'h800000fe, "byte lanes");
      $display("test interrupt and bus done");
   endtask
   task automatic t_rst;
      wr(`DXE_A_IMSK, 32'h3);
      ex(`DXE_OP_SINGLE_ADD_OP, 8'h01, 8'h02, 8'h03);
      repeat (2) @(posedge clk);
      chk("irq before reset", 1, irq);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      chk("irq in reset", 0, irq);
      chk("bvalid in reset", 0, s_axi_bvalid);
      chk("rvalid in reset", 0, s_axi_rvalid);
      rstn <= 1'b1;
      rd(`DXE_A_ALU, 32'h0, "alu after reset");
      rd(`DXE_A_IST, 32'h0, "status after reset");
      rd(`DXE_A_TRAP, 32'h0, "trap after reset");
      rd(`DXE_A_IMSK, 32'h0, "mask after reset");
      $display("test reset done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      t_div();
      t_ext();
      t_fp();
      t_emu();
      t_irq();
      t_rst();
      report_and_stop();
   end
endmodule
bind dxe_exec_top dxe_exec_sva dxe_exec_sva_inst (.clk, .rstn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);
